// ===== ast_snooze_trigger.v
// Snooze-mode trigger control: registers, interval timer, event link and converter sequencing.
// Assumes an Avalon-MM master on clk; sampleIn and sleeping arrive from other logic on clk.
//
// Notes on behaviour
// - Mode-zero bit 0 set runs the converter comparator; cleared stops it.
// - Request flag bit 0 sets when a conversion ends; reads 0 when none pending.
// - Writing 0 to the request flag clears a pending request.
// - Mask bit 0 at 0 lets the request be serviced; 1 blocks it.
// - Timer control bit 0 at 1 runs the timer count; 0 stops it.
// - Mode-two bit 2 enables snooze: triggered conversions run while the processor sleeps.
// - Timer event comes every reload plus one count-clock periods.
// - Link select 0001 sends timer events to the converter; 0000 disables the link.
`timescale 1ns/1ps
`include "ast_consts.vh"
module ast_snooze_trigger #(
   parameter RES_WIDTH = 10,
   parameter TMR_WIDTH = 16
) (
   input  wire                 clk,
   input  wire                 resetn,
   input  wire [5:0]           address,
   input  wire                 read,
   input  wire                 write,
   input  wire [31:0]          writedata,
   input  wire [3:0]           byteenable,
   output reg  [31:0]          readdata,
   output wire                 waitrequest,
   input  wire                 countTick,
   input  wire                 sleeping,
   input  wire [RES_WIDTH-1:0] sampleIn,
   output wire                 comparatorOn,
   output wire                 convEndRequest,
   output wire                 wakeRequest,
   output wire                 timerPeriodEvent,
   output wire                 irq
);
   reg  [7:0]           modeZero_r;
   reg  [7:0]           reqFlags_r;
   reg  [7:0]           maskFlags_r;
   reg  [7:0]           timerCtrl_r;
   reg  [7:0]           modeTwo_r;
   reg  [TMR_WIDTH-1:0] reload_r;
   reg  [3:0]           linkSel_r;
   reg  [2:0]           irqStatus_r;
   reg  [2:0]           irqEnable_r;
   reg  [15:0]          convCount_r;
   reg                  ack_r;
   wire [3:0]           regIdx;
   wire                 wrHit;
   wire                 convBusy;
   wire                 convDone;
   wire [RES_WIDTH-1:0] convResult;
   wire                 linkToConv;
   wire                 convStart;
   wire                 trigLost;
   wire                 clearReq;

   // Write of one byte lane of a register, at the one cycle the access completes.
   function wrLow;
      input [3:0] idx;
      input [3:0] target;
      input       wr;
      input       lane;
      begin
         wrLow = wr & lane & (idx == target);
      end
   endfunction

   assign regIdx      = address[5:2];
   assign waitrequest = (read | write) & ~ack_r;
   assign wrHit       = write & ~waitrequest;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (read | write) & ~ack_r;
      end
   end

   assign comparatorOn = modeZero_r[`AST_BIT_COMPARATOR];
   assign linkToConv   = (linkSel_r == `AST_LINK_CONVERTER);
   // Timer events start conversions only when linked and the comparator is on.
   // In snooze mode a trigger is taken while the processor sleeps; with snooze off
   // the processor must be awake for the trigger to start a conversion.
   assign convStart = timerPeriodEvent & linkToConv & comparatorOn
                      & (modeTwo_r[`AST_BIT_SNOOZE] | ~sleeping) & ~convBusy;
   assign trigLost  = timerPeriodEvent & linkToConv & ~convStart;
   assign convEndRequest = reqFlags_r[`AST_BIT_CONV_REQ];
   assign wakeRequest = convEndRequest & ~maskFlags_r[`AST_BIT_CONV_MASK];
   assign irq = |(irqStatus_r & irqEnable_r);
   assign clearReq = wrLow(regIdx, `AST_OFF_REQ_FLAGS, wrHit, byteenable[0])
                     & ~writedata[`AST_BIT_CONV_REQ];

   ast_interval_timer #(
      .WIDTH (TMR_WIDTH)
   ) uTimer (
      .clk         (clk),
      .resetn      (resetn),
      .run         (timerCtrl_r[`AST_BIT_TIMER_RUN]),
      .countTick   (countTick),
      .reload      (reload_r),
      .periodEvent (timerPeriodEvent)
   );

   ast_converter #(
      .RES_WIDTH (RES_WIDTH)
   ) uConv (
      .clk          (clk),
      .resetn       (resetn),
      .comparatorOn (comparatorOn),
      .start        (convStart),
      .sampleIn     (sampleIn),
      .busy         (convBusy),
      .done         (convDone),
      .result       (convResult)
   );

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         modeZero_r  <= `AST_RST_MODE_ZERO;
         maskFlags_r <= `AST_RST_MASK_FLAGS;
         timerCtrl_r <= `AST_RST_TIMER_CTRL;
         modeTwo_r   <= `AST_RST_MODE_TWO;
         reload_r    <= `AST_RST_RELOAD;
         linkSel_r   <= `AST_RST_LINK_SEL;
         irqEnable_r <= 3'h0;
      end else begin
         if (wrLow(regIdx, `AST_OFF_MODE_ZERO, wrHit, byteenable[0])) begin
            modeZero_r <= writedata[7:0];
         end
         if (wrLow(regIdx, `AST_OFF_MASK_FLAGS, wrHit, byteenable[0])) begin
            maskFlags_r <= writedata[7:0];
         end
         if (wrLow(regIdx, `AST_OFF_TIMER_CTRL, wrHit, byteenable[0])) begin
            // Only the run bit is writable; the others read as zero.
            timerCtrl_r <= {7'h00, writedata[`AST_BIT_TIMER_RUN]};
         end
         if (wrLow(regIdx, `AST_OFF_MODE_TWO, wrHit, byteenable[0])) begin
            modeTwo_r <= writedata[7:0];
         end
         if (wrLow(regIdx, `AST_OFF_RELOAD, wrHit, byteenable[0])) begin
            reload_r[7:0] <= writedata[7:0];
         end
         if (wrLow(regIdx, `AST_OFF_RELOAD, wrHit, byteenable[1])) begin
            reload_r[TMR_WIDTH-1:8] <= writedata[TMR_WIDTH-1:8];
         end
         if (wrLow(regIdx, `AST_OFF_LINK_SEL, wrHit, byteenable[0])) begin
            linkSel_r <= writedata[3:0];
         end
         if (wrLow(regIdx, `AST_OFF_IRQ_ENABLE, wrHit, byteenable[0])) begin
            irqEnable_r <= writedata[2:0];
         end
      end
   end

   // Request flags: hardware set wins over a software clear in the same cycle.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reqFlags_r <= `AST_RST_REQ_FLAGS;
      end else begin
         if (wrLow(regIdx, `AST_OFF_REQ_FLAGS, wrHit, byteenable[0])) begin
            // Writing 1 leaves a bit as it was; writing 0 clears it.
            reqFlags_r[7:1] <= reqFlags_r[7:1] & writedata[7:1];
         end
         if (convDone) begin
            reqFlags_r[`AST_BIT_CONV_REQ] <= 1'b1;
         end else if (clearReq) begin
            reqFlags_r[`AST_BIT_CONV_REQ] <= 1'b0;
         end
      end
   end

   // Sticky interrupt status with write-one-to-clear; a new event beats its clear.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqStatus_r <= 3'h0;
      end else begin
         if (wrLow(regIdx, `AST_OFF_IRQ_CLEAR, wrHit, byteenable[0])) begin
            irqStatus_r <= (irqStatus_r & ~writedata[2:0])
                           | {trigLost, timerPeriodEvent, convDone};
         end else begin
            irqStatus_r <= irqStatus_r | {trigLost, timerPeriodEvent, convDone};
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         convCount_r <= 16'h0000;
      end else if (convDone) begin
         convCount_r <= convCount_r + 16'h0001;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ack_r) begin
         case (regIdx)
            `AST_OFF_MODE_ZERO:   readdata <= {24'h000000, modeZero_r};
            `AST_OFF_REQ_FLAGS:   readdata <= {24'h000000, reqFlags_r};
            `AST_OFF_MASK_FLAGS:  readdata <= {24'h000000, maskFlags_r};
            `AST_OFF_TIMER_CTRL:  readdata <= {24'h000000, timerCtrl_r};
            `AST_OFF_MODE_TWO:    readdata <= {24'h000000, modeTwo_r};
            `AST_OFF_RELOAD:      readdata <= {{(32-TMR_WIDTH){1'b0}}, reload_r};
            `AST_OFF_LINK_SEL:    readdata <= {28'h0000000, linkSel_r};
            `AST_OFF_IRQ_STATUS:  readdata <= {29'h00000000, irqStatus_r};
            `AST_OFF_IRQ_ENABLE:  readdata <= {29'h00000000, irqEnable_r};
            `AST_OFF_CONV_RESULT: readdata <= {{(32-RES_WIDTH){1'b0}}, convResult};
            `AST_OFF_CONV_COUNT:  readdata <= {16'h0000, convCount_r};
            default:              readdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// ===== ast_consts.vh
// Register offsets, field positions, reset values and timing counts of the snooze trigger block.
// Included by the top design file of the block only; definitions only.
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH

`define AST_OFF_MODE_ZERO     4'h0
`define AST_OFF_REQ_FLAGS     4'h1
`define AST_OFF_MASK_FLAGS    4'h2
`define AST_OFF_TIMER_CTRL    4'h3
`define AST_OFF_MODE_TWO      4'h4
`define AST_OFF_RELOAD        4'h5
`define AST_OFF_LINK_SEL      4'h6
`define AST_OFF_IRQ_STATUS    4'h7
`define AST_OFF_IRQ_CLEAR     4'h8
`define AST_OFF_IRQ_ENABLE    4'h9
`define AST_OFF_CONV_RESULT   4'ha
`define AST_OFF_CONV_COUNT    4'hb

`define AST_BIT_COMPARATOR    0
`define AST_BIT_CONV_REQ      0
`define AST_BIT_CONV_MASK     0
`define AST_BIT_TIMER_RUN     0
`define AST_BIT_SNOOZE        2

`define AST_RST_MODE_ZERO     8'h00
`define AST_RST_REQ_FLAGS     8'h00
`define AST_RST_MASK_FLAGS    8'hff
`define AST_RST_TIMER_CTRL    8'h00
`define AST_RST_MODE_TWO      8'h00
`define AST_RST_RELOAD        16'hffff
`define AST_RST_LINK_SEL      4'h0

`define AST_LINK_OFF          4'h0
`define AST_LINK_CONVERTER    4'h1

`define AST_IRQ_CONV_END      0
`define AST_IRQ_TIMER_EVENT   1
`define AST_IRQ_TRIG_LOST     2

`define AST_CONV_CYCLES       8'd20

`endif

// ===== ast_interval_timer.v
// Interval timer: down-counter that reloads and pulses once every reload plus one periods.
// Assumes a count-clock tick pulse of one clk cycle from the same clock domain.
`timescale 1ns/1ps
module ast_interval_timer #(
   parameter WIDTH = 16
) (
   input  wire             clk,
   input  wire             resetn,
   input  wire             run,
   input  wire             countTick,
   input  wire [WIDTH-1:0] reload,
   output reg              periodEvent
);
   reg [WIDTH-1:0] count_r;
   reg             running_r;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r     <= {WIDTH{1'b0}};
         running_r   <= 1'b0;
         periodEvent <= 1'b0;
      end else begin
         running_r   <= run;
         periodEvent <= 1'b0;
         if (!run) begin
            count_r <= reload;
         end else if (!running_r) begin
            count_r <= reload;
         end else if (countTick) begin
            if (count_r == {WIDTH{1'b0}}) begin
               // Zero counts as one period, so reload N gives N plus one ticks.
               count_r     <= reload;
               periodEvent <= 1'b1;
            end else begin
               count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// ===== ast_converter.v
// Converter sequencer: runs one conversion of fixed length per accepted start pulse.
// Assumes a sampled analog code on sampleIn, stable during a conversion.
`timescale 1ns/1ps
module ast_converter #(
   parameter RES_WIDTH = 10
) (
   input  wire                 clk,
   input  wire                 resetn,
   input  wire                 comparatorOn,
   input  wire                 start,
   input  wire [RES_WIDTH-1:0] sampleIn,
   output wire                 busy,
   output reg                  done,
   output reg  [RES_WIDTH-1:0] result
);
   reg [7:0] left_r;

   assign busy = (left_r != 8'h00);

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_r <= 8'h00;
         done   <= 1'b0;
         result <= {RES_WIDTH{1'b0}};
      end else begin
         done <= 1'b0;
         if (!comparatorOn) begin
            // A stopped comparator aborts any conversion in progress.
            left_r <= 8'h00;
         end else if (left_r == 8'h00) begin
            if (start) begin
               left_r <= `AST_CONV_CYCLES;
            end
         end else if (left_r == 8'h01) begin
            left_r <= 8'h00;
            done   <= 1'b1;
            result <= sampleIn;
         end else begin
            left_r <= left_r - 8'h01;
         end
      end
   end
endmodule

// ===== ast_snooze_trigger_monitor.sv
// Concurrent checks on the ports of the snooze trigger block.
// Bound to every ast_snooze_trigger instance; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module ast_snooze_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        countTick,
   input wire logic        comparatorOn,
   input wire logic        convEndRequest,
   input wire logic        wakeRequest,
   input wire logic        timerPeriodEvent
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire acc = (read | write) & ~waitrequest;
   logic maskSeen;

   // Mask bit as software last wrote it; it resets to blocked.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         maskSeen <= 1'b1;
      end else if (acc && write && byteenable[0] && address[5:2] == 4'h2) begin
         maskSeen <= writedata[0];
      end
   end
   sequence s_ack;
      (read | write) && waitrequest ##1 !waitrequest;
   endsequence
   property p_ack;
      $rose(read | write) |-> s_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered after one cycle");
   property p_onecyc;
      acc |=> waitrequest || !(read | write);
   endproperty
   a_onecyc: assert property (p_onecyc) else $error("bus answer held beyond one cycle");
   property p_unmapped;
      read && acc && address[5:2] > 4'hb |-> readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read returned nonzero");
   property p_comp;
      $changed(comparatorOn) |-> $past(acc && write && address[5:2] == 4'h0)
         && comparatorOn == $past(writedata[0]);
   endproperty
   a_comp: assert property (p_comp) else $error("comparator changed without its write");
   property p_done;
      $rose(convEndRequest) |-> $past(comparatorOn, 20);
   endproperty
   a_done: assert property (p_done) else $error("request flag set without a conversion");
   property p_clear;
      $fell(convEndRequest) |-> $past(acc && write && address[5:2] == 4'h1 && !writedata[0]);
   endproperty
   a_clear: assert property (p_clear) else $error("request flag fell without a zero write");
   property p_wake;
      wakeRequest == (convEndRequest && !maskSeen);
   endproperty
   a_wake: assert property (p_wake) else $error("service request without pending flag");
   property p_tick;
      timerPeriodEvent |-> $past(countTick);
   endproperty
   a_tick: assert property (p_tick) else $error("timer event without a count tick");
endmodule

bind ast_snooze_trigger ast_snooze_monitor u_mon (
   .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest),
   .countTick(countTick), .comparatorOn(comparatorOn), .convEndRequest(convEndRequest),
   .wakeRequest(wakeRequest), .timerPeriodEvent(timerPeriodEvent)
);

// ===== ast_tb.sv
// Self-checking bench of the snooze trigger block.
// Drives the Avalon-MM port itself; count tick every cycle or every other cycle, fixed analog code.
`timescale 1ns/1ps
module tb;
   logic        clk       = 1'b0;
   logic        resetn    = 1'b0;
   logic [5:0]  address   = 6'h00;
   logic        read      = 1'b0;
   logic        write     = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic        sleeping  = 1'b0;
   logic        countTick = 1'b1;
   logic        tickHalf  = 1'b0;
   wire  [31:0] readdata;
   wire         waitrequest, comparatorOn, convEndRequest, wakeRequest, timerPeriodEvent, irq;
   int          fails     = 0;
   int          tests_run = 0;
   logic [31:0] q;
   int          n;

   ast_snooze_trigger dut (
      .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .countTick(countTick), .sleeping(sleeping),
      .sampleIn(10'h2a5), .comparatorOn(comparatorOn), .convEndRequest(convEndRequest),
      .wakeRequest(wakeRequest), .timerPeriodEvent(timerPeriodEvent), .irq(irq)
   );

   initial begin
      forever #50 clk = ~clk;
   end

   // The count tick runs every cycle, or on every other cycle while tickHalf is set.
   always @(posedge clk) begin
      countTick <= tickHalf ? ~countTick : 1'b1;
   end

   task print_verdict;
      $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One bus cycle, entered just after a rising edge. The request stands until the rising
   // edge at which waitrequest is seen low; read data is taken at that edge, then released.
   task bus(input logic w, input logic [3:0] i, input logic [31:0] d);
      int k;
      address <= {i, 2'b00};
      read <= !w;
      write <= w;
      writedata <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      if (k == 20) begin
         fails++;
         $display("Error bus answer expected 0 seen 1");
         print_verdict;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [3:0] i, input logic [31:0] d);
      bus(1'b1, i, d);
   endtask

   task rd(input logic [3:0] i);
      bus(1'b0, i, 32'h0);
   endtask

   // Runs c cycles and counts timer events.
   task watch(input int c);
      n = 0;
      repeat (c) begin
         @(negedge clk);
         if (timerPeriodEvent === 1'b1) n++;
      end
      @(posedge clk);
   endtask

   task t_reset;
      logic [31:0] rv [8];
      int i;
      rv = '{32'h0, 32'h0, 32'hff, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0};
      for (i = 0; i < 8; i++) begin
         rd(i[3:0]);
         chk("reset value", rv[i], q);
      end
      rd(4'hc);
      chk("unmapped read", 32'h0, q);
      chk("outputs", 32'h0, {comparatorOn, convEndRequest, wakeRequest, timerPeriodEvent, irq});
   endtask

   task t_trigger;
      wr(4'h0, 32'h1);
      chk("comparatorOn", 32'h1, comparatorOn);
      wr(4'h1, 32'h0);
      wr(4'h2, 32'h0);
      wr(4'h5, 32'd39);
      wr(4'h6, 32'h1);
      wr(4'h9, 32'h7);
      wr(4'h3, 32'h1);
      watch(20);
      watch(80);
      chk("events in 80 cycles", 32'd2, n);
      chk("request flag", 32'h1, convEndRequest);
      chk("wakeRequest", 32'h1, wakeRequest);
      chk("irq", 32'h1, irq);
      rd(4'ha);
      chk("result", 32'h2a5, q);
      rd(4'h7);
      chk("irq status", 32'h3, q);
      rd(4'hb);
      chk("conversion count", 32'd2, q);
      wr(4'h3, 32'h0);
      watch(40);
      watch(100);
      chk("events stopped", 32'h0, n);
   endtask

   task t_flags;
      wr(4'h2, 32'h1);
      chk("masked wakeRequest", 32'h0, wakeRequest);
      wr(4'h1, 32'h1);
      chk("flag kept", 32'h1, convEndRequest);
      wr(4'h1, 32'h0);
      chk("flag cleared", 32'h0, convEndRequest);
      wr(4'h9, 32'h0);
      chk("irq disabled", 32'h0, irq);
      wr(4'h9, 32'h7);
      chk("irq enabled", 32'h1, irq);
      wr(4'h8, 32'h7);
      rd(4'h7);
      chk("irq status cleared", 32'h0, q);
      chk("irq after clear", 32'h0, irq);
   endtask

   task t_snooze;
      sleeping <= 1'b1;
      wr(4'h4, 32'h0);
      wr(4'h3, 32'h1);
      watch(100);
      chk("no conversion asleep", 32'h0, convEndRequest);
      rd(4'h7);
      chk("trigger lost", 32'h1, q[2]);
      wr(4'h4, 32'h4);
      watch(100);
      chk("snooze conversion", 32'h1, convEndRequest);
      wr(4'h6, 32'h0);
      watch(60);
      wr(4'h1, 32'h0);
      watch(100);
      chk("link off", 32'h0, convEndRequest);
      wr(4'h4, 32'h0);
      wr(4'h3, 32'h0);
      sleeping <= 1'b0;
   endtask

   // Ticks on every other cycle: a reload of nine gives an event every twenty cycles.
   task t_tick;
      tickHalf <= 1'b1;
      wr(4'h5, 32'd9);
      wr(4'h3, 32'h1);
      watch(30);
      watch(80);
      chk("events at half tick rate", 32'd4, n);
      wr(4'h3, 32'h0);
      tickHalf <= 1'b0;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_trigger;
      t_flags;
      t_snooze;
      t_tick;
      print_verdict;
   end
endmodule
